// ===== common/esq_map.vh
`ifndef ESQ_MAP_VH
`define ESQ_MAP_VH
// Printed offsets are not word multiples: byte address = 4 * index
`define ESQ_IDX_L1_INSTR 12'hE55
`define ESQ_IDX_L1_ADDR_A 12'hE56
`define ESQ_IDX_L1_ADDR_B 12'hE57
`define ESQ_IDX_L2_INSTR 12'hE58
`define ESQ_IDX_L2_ADDR_A 12'hE59
`define ESQ_IDX_L2_ADDR_B 12'hE5A
`define ESQ_IDX_L3_INSTR 12'hE5B
`define ESQ_IDX_L3_ADDR_A 12'hE5C
`define ESQ_IDX_L3_ADDR_B 12'hE5D
`define ESQ_IDX_CTRL 12'hE70
`define ESQ_IDX_STATUS 12'hE71
`define ESQ_IDX_PTR 12'hE72
`define ESQ_RST_INSTR 8'h04
`define ESQ_RST_L1_ADDR 16'h0A40
`define ESQ_RST_L2_ADDR 16'h0A60
`define ESQ_RST_L3_ADDR 16'h0A80
`define ESQ_OP_END 8'hFF
`define ESQ_OP_PAUSE 8'hFE
`define ESQ_CRC_BYTES 3'h4
`define ESQ_CTRL_START 0
`define ESQ_STAT_BUSY 0
`define ESQ_STAT_DONE 1
`endif

// ===== rtl/esq_save_ctrl.v
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
`include "esq_map.vh"
module esq_save_ctrl #(
   parameter PTR_W = 16
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [15:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Register-map read port
   output reg [15:0] map_adr_o,
   output reg map_rd_o,
   input wire [7:0] map_dat_i,
   // EEPROM byte write port
   output reg ee_wr_o,
   output reg [PTR_W-1:0] ee_adr_o,
   output reg [7:0] ee_dat_o,
   input wire ee_rdy_i,
   // CRC byte supply
   input wire [7:0] crc_dat_i,
   output wire crc_clr_o
);

   localparam [7:0] S_IDLE = 8'h01;
   localparam [7:0] S_FETCH = 8'h02;
   localparam [7:0] S_INSTR = 8'h04;
   localparam [7:0] S_ADDR = 8'h08;
   localparam [7:0] S_RDMAP = 8'h10;
   localparam [7:0] S_COPY = 8'h20;
   localparam [7:0] S_CRC = 8'h40;
   localparam [7:0] S_SPARE = 8'h80;

   reg [7:0] state_q;
   reg [7:0] state_d;
   reg [3:0] idx_q;
   reg [3:0] idx_d;
   reg [7:0] instr_q;
   reg [7:0] instr_d;
   reg [15:0] src_q;
   reg [15:0] src_d;
   reg [8:0] left_q;
   reg [8:0] left_d;
   reg [1:0] sub_q;
   reg [1:0] sub_d;
   reg [2:0] crc_q;
   reg [2:0] crc_d;
   reg [PTR_W-1:0] ptr_q;
   reg [PTR_W-1:0] ptr_d;
   reg done_q;
   reg done_d;
   reg [7:0] map_q;
   reg [7:0] map_d;
   reg have_q;
   reg have_d;
   reg map_vld_q;
   reg start_q;
   reg [31:0] rd_dat_d;
   // Next values of the registered outputs
   reg ee_wr_d;
   reg [PTR_W-1:0] ee_adr_d;
   reg [7:0] ee_dat_d;
   reg map_rd_d;
   reg [15:0] map_adr_d;

   wire [15:0] rst_adr [0:2];
   wire [7:0] list_w [0:8];
   wire [11:0] widx = wb_adr_i[13:2];
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr_req = req & wb_we_i & wb_sel_i[0];
   wire [11:0] list_off = widx - `ESQ_IDX_L1_INSTR;
   wire [15:0] wr_dec = 16'h0001 << list_off[3:0];
   wire in_list = (widx >= `ESQ_IDX_L1_INSTR) && (widx <= `ESQ_IDX_L3_ADDR_B);
   wire busy = (state_q != S_IDLE);
   // Past the last entry nothing is stored: fetch reads as end
   wire [7:0] cur_byte = (idx_q < 4'd9) ? list_w[idx_q] : `ESQ_OP_END;
   wire is_stop = (instr_q == `ESQ_OP_END) || (instr_q == `ESQ_OP_PAUSE);

   assign crc_clr_o = start_q;

   assign rst_adr[0] = `ESQ_RST_L1_ADDR;
   assign rst_adr[1] = `ESQ_RST_L2_ADDR;
   assign rst_adr[2] = `ESQ_RST_L3_ADDR;

   // One byte per list slot; the list is frozen while the walk runs
   genvar g;
   generate
      for (g = 0; g < 9; g = g + 1) begin : g_slot
         wire [15:0] dflt_adr;
         wire [7:0] dflt;
         reg [7:0] slot_q;
         assign dflt_adr = rst_adr[g / 3];
         // Slot order in an entry: count, address high, address low
         assign dflt = (g % 3 == 0) ? `ESQ_RST_INSTR :
            ((g % 3 == 1) ? dflt_adr[15:8] : dflt_adr[7:0]);
         assign list_w[g] = slot_q;
         always @(posedge clk_i) begin
            if (rst_i) begin
               slot_q <= dflt;
            end else if (wr_req && in_list && !busy && wr_dec[g]) begin
               slot_q <= wb_dat_i[7:0];
            end
         end
      end
   endgenerate

   // Unmapped indices read as zero
   always @* begin
      rd_dat_d = 32'h0000_0000;
      if (in_list) begin
         rd_dat_d = {24'h000000, list_w[list_off[3:0]]};
      end else if (widx == `ESQ_IDX_STATUS) begin
         rd_dat_d = {30'h0, done_q, busy};
      end else if (widx == `ESQ_IDX_PTR) begin
         rd_dat_d = {{(32-PTR_W){1'b0}}, ptr_q};
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         start_q <= 1'b0;
      end else begin
         wb_ack_o <= req;
         start_q <= wr_req && (widx == `ESQ_IDX_CTRL) && wb_dat_i[`ESQ_CTRL_START] && !busy;
         if (req) begin
            wb_dat_o <= rd_dat_d;
         end
      end
   end

   // Sequencer walk, next-state part
   always @* begin
      state_d = state_q;
      idx_d = idx_q;
      instr_d = instr_q;
      src_d = src_q;
      left_d = left_q;
      sub_d = sub_q;
      crc_d = crc_q;
      ptr_d = ptr_q;
      done_d = done_q;
      // Map data stands one cycle only; keep it if the EEPROM stalls
      map_d = map_vld_q ? map_dat_i : map_q;
      have_d = have_q | map_vld_q;
      ee_wr_d = 1'b0;
      ee_adr_d = ee_adr_o;
      ee_dat_d = ee_dat_o;
      map_rd_d = 1'b0;
      map_adr_d = map_adr_o;
      case (state_q)
         S_IDLE: begin
            if (start_q) begin
               done_d = 1'b0;
               idx_d = 4'h0;
               state_d = S_FETCH;
            end
         end

         S_FETCH: begin
            instr_d = cur_byte;
            idx_d = idx_q + 4'h1;
            left_d = {1'b0, cur_byte} + 9'h001;
            sub_d = 2'h0;
            state_d = S_INSTR;
         end

         S_INSTR: begin
            if (ee_rdy_i) begin
               ee_wr_d = 1'b1;
               ee_adr_d = ptr_q;
               ee_dat_d = instr_q;
               ptr_d = ptr_q + 1'b1;
               crc_d = 3'h0;
               state_d = is_stop ? S_CRC : S_ADDR;
            end
         end

         S_ADDR: begin
            if (ee_rdy_i) begin
               ee_wr_d = 1'b1;
               ee_adr_d = ptr_q;
               ee_dat_d = cur_byte;
               ptr_d = ptr_q + 1'b1;
               idx_d = idx_q + 4'h1;
               if (sub_q == 2'h0) begin
                  src_d[15:8] = cur_byte;
                  sub_d = 2'h1;
               end else begin
                  src_d[7:0] = cur_byte;
                  state_d = S_RDMAP;
               end
            end
         end

         S_RDMAP: begin
            map_rd_d = 1'b1;
            map_adr_d = src_q;
            have_d = 1'b0;
            state_d = S_COPY;
         end

         S_COPY: begin
            // Map data is valid in the cycle after the read strobe
            if (ee_rdy_i && (map_vld_q || have_q)) begin
               ee_wr_d = 1'b1;
               ee_adr_d = ptr_q;
               ee_dat_d = map_d;
               ptr_d = ptr_q + 1'b1;
               src_d = src_q + 16'h0001;
               left_d = left_q - 9'h001;
               have_d = 1'b0;
               state_d = (left_q == 9'h001) ? S_FETCH : S_RDMAP;
            end
         end

         S_CRC: begin
            if (ee_rdy_i) begin
               ee_wr_d = 1'b1;
               ee_adr_d = ptr_q;
               ee_dat_d = crc_dat_i;
               crc_d = crc_q + 3'h1;
               if (crc_q == `ESQ_CRC_BYTES - 3'h1) begin
                  // End rewinds for a fresh profile, pause stacks the next one
                  ptr_d = (instr_q == `ESQ_OP_END) ? {PTR_W{1'b0}} : ptr_q + 1'b1;
                  done_d = 1'b1;
                  state_d = S_IDLE;
               end else begin
                  ptr_d = ptr_q + 1'b1;
               end
            end
         end

         default: begin
            state_d = S_IDLE;
         end
      endcase
   end

   // Sequencer walk, state registers
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= S_IDLE;
         idx_q <= 4'h0;
         instr_q <= 8'h00;
         src_q <= 16'h0000;
         left_q <= 9'h000;
         sub_q <= 2'h0;
         crc_q <= 3'h0;
         ptr_q <= {PTR_W{1'b0}};
         done_q <= 1'b0;
         map_q <= 8'h00;
         have_q <= 1'b0;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         instr_q <= instr_d;
         src_q <= src_d;
         left_q <= left_d;
         sub_q <= sub_d;
         crc_q <= crc_d;
         ptr_q <= ptr_d;
         done_q <= done_d;
         map_q <= map_d;
         have_q <= have_d;
      end
   end

   // EEPROM byte write port
   always @(posedge clk_i) begin
      if (rst_i) begin
         ee_wr_o <= 1'b0;
         ee_adr_o <= {PTR_W{1'b0}};
         ee_dat_o <= 8'h00;
      end else begin
         ee_wr_o <= ee_wr_d;
         ee_adr_o <= ee_adr_d;
         ee_dat_o <= ee_dat_d;
      end
   end

   // Register-map read port; map_vld_q marks the cycle the data stands
   always @(posedge clk_i) begin
      if (rst_i) begin
         map_rd_o <= 1'b0;
         map_adr_o <= 16'h0000;
         map_vld_q <= 1'b0;
      end else begin
         map_rd_o <= map_rd_d;
         map_adr_o <= map_adr_d;
         map_vld_q <= map_rd_o;
      end
   end

endmodule

// ===== tb/esq_props.sv
`timescale 1ns/1ps
module esq_props #(
   parameter PTR_W = 16
) (
   // Clock, reset and bus
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   // Sequencer side
   input wire map_rd_o,
   input wire ee_wr_o,
   input wire [PTR_W-1:0] ee_adr_o,
   input wire [7:0] ee_dat_o,
   input wire crc_clr_o
);
   reg [PTR_W-1:0] last_q;
   reg seen_q;
   always @(posedge clk_i) begin
      seen_q <= !rst_i && (seen_q || ee_wr_o);
      if (ee_wr_o) last_q <= ee_adr_o;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
   reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !ee_wr_o && !map_rd_o)
      else $error("active in reset");
   copy_write_a: assert property (map_rd_o |-> ##[2:24] ee_wr_o) else $error("byte lost");
   ptr_step_a: assert property (ee_wr_o && seen_q |-> ee_adr_o == last_q + 1'b1 || ee_adr_o == 0)
      else $error("pointer jump");
   read_pulse_a: assert property (map_rd_o |=> !map_rd_o) else $error("read too long");
   clr_pulse_a: assert property (crc_clr_o |=> !crc_clr_o) else $error("clear too long");
   cover property (ee_wr_o && ee_dat_o == 8'hFF);
   cover property (ee_wr_o && ee_dat_o == 8'hFE);
   cover property (map_rd_o);
endmodule
bind esq_save_ctrl esq_props #(.PTR_W(PTR_W)) esq_props_inst (.*);

// ===== tb/esq_ee_model.sv
`timescale 1ns/1ps
module esq_ee_model (
   // Clock and pacing
   input wire clk_i,
   input wire slow_i,
   // Byte writes and map reads
   input wire ee_wr_i,
   input wire [15:0] ee_adr_i,
   input wire [7:0] ee_dat_i,
   input wire map_rd_i,
   input wire [15:0] map_adr_i,
   output reg ee_rdy_o = 1'b0,
   output reg [7:0] map_dat_o = 8'h00
);
   reg [7:0] mem [0:255];
   always @(posedge clk_i) begin
      ee_rdy_o <= !slow_i || !ee_rdy_o;
      if (ee_wr_i) mem[ee_adr_i[7:0]] <= ee_dat_i;
      // Garbage outside the valid cycle
      map_dat_o <= map_rd_i ? (map_adr_i[7:0] ^ 8'h5A) : ~map_dat_o;
   end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg cyc = 1'b0;
   reg we = 1'b0;
   reg slow = 1'b0;
   reg [15:0] adr = 16'h0000;
   reg [31:0] wdat = 32'h0000_0000;
   wire [31:0] rdat;
   wire [15:0] madr, eadr;
   wire [7:0] mdat, edat;
   wire ack, mrd, ewr, erdy;
   integer err_total = 0, num_checks = 0, i;
   reg [31:0] r;
   reg [7:0] exp [$];
   reg [7:0] dflt [0:8] = '{8'h04, 8'h0A, 8'h40, 8'h04, 8'h0A, 8'h60, 8'h04, 8'h0A, 8'h80};
   always #10 clk_i = ~clk_i;
   esq_save_ctrl esq_save_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .map_adr_o(madr), .map_rd_o(mrd), .map_dat_i(mdat), .ee_wr_o(ewr),
      .ee_adr_o(eadr), .ee_dat_o(edat), .ee_rdy_i(erdy), .crc_dat_i(8'hC3), .crc_clr_o());
   esq_ee_model esq_ee_model_inst (.clk_i(clk_i), .slow_i(slow), .ee_wr_i(ewr), .ee_adr_i(eadr),
      .ee_dat_i(edat), .map_rd_i(mrd), .map_adr_i(madr), .ee_rdy_o(erdy), .map_dat_o(mdat));
   task close_out;
      begin
         $display("checks %0d errors %0d", num_checks, err_total);
         if (err_total == 0 && num_checks > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] want);
      begin
         num_checks = num_checks + 1;
         if (got !== want) begin
            err_total = err_total + 1;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
         end
      end
   endtask
   task wb(input w, input [11:0] idx, input [31:0] d);
      integer n;
      begin
         @(posedge clk_i);
         cyc <= 1'b1;
         we <= w;
         adr <= {2'b00, idx, 2'b00};
         wdat <= d;
         n = 0;
         // Ack is looked at where it is settled, released at the edge it is taken
         do begin
            @(negedge clk_i);
            n = n + 1;
         end while (ack !== 1'b1 && n < 20);
         chk(n < 20, 1);
         if (n >= 20) close_out;
         r = rdat;
         @(posedge clk_i);
         cyc <= 1'b0;
      end
   endtask
   task rd(input [11:0] idx, input [31:0] want);
      begin
         wb(1'b0, idx, 0);
         chk(r, want);
      end
   endtask
   task put(input [7:0] b);
      exp.push_back(b);
   endtask
   task ent(input [7:0] n, input [15:0] a);
      integer k;
      begin
         put(n);
         put(a[15:8]);
         put(a[7:0]);
         for (k = 0; k <= n; k++) put((a[7:0] + k) ^ 8'h5A);
      end
   endtask
   // Expected stream must be queued before each run
   task run(input [31:0] ptr);
      integer n;
      begin
         wb(1'b1, 12'hE70, 1);
         r = 0;
         for (n = 0; r[1] !== 1'b1 && n < 300; n++) wb(1'b0, 12'hE71, 0);
         chk(n < 300, 1);
         if (n >= 300) close_out;
         for (n = 0; n < exp.size(); n++) chk(esq_ee_model_inst.mem[n], exp[n]);
         rd(12'hE72, ptr);
         exp.delete();
      end
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 9; i++) rd(12'hE55 + i, dflt[i]);
      rd(12'hE00, 0);
      ent(4, 16'h0A40);
      ent(4, 16'h0A60);
      ent(4, 16'h0A80);
      put(8'hFF);
      repeat (4) put(8'hC3);
      run(0);
      wb(1'b1, 12'hE55, 1);
      wb(1'b1, 12'hE56, 8'h0B);
      wb(1'b1, 12'hE57, 8'h10);
      wb(1'b1, 12'hE5B, 8'hFE);
      rd(12'hE55, 1);
      slow <= 1'b1;
      ent(1, 16'h0B10);
      ent(4, 16'h0A60);
      put(8'hFE);
      repeat (4) put(8'hC3);
      run(18);
      close_out;
   end
endmodule
